//--- bench/ocs_ctrl_monitor.sv
// port checker for the cycle-skip controller
// assumes it is bound to ocs_ctrl
`timescale 1ns/1ns
`default_nettype none
module ocs_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire logic ilim_reached_i,
  input wire logic switch_on_o,
  input wire logic [1:0] ilim_code_o,
  input wire logic [1:0] load_state_o,
  input wire logic line_uv_active_o,
  input wire logic cycle_start_o,
  input wire logic max_duty_window_o
);
  logic [10:0] gap;
  logic seen;
  // first period after reset is not judged
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap <= 11'h0;
      seen <= 1'b0;
    end else begin
      gap <= cycle_start_o ? 11'h1 : gap + 11'h1;
      seen <= seen | cycle_start_o;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_code_idle: assert property (!switch_on_o |-> ilim_code_o == 2'h0)
    else $error("code while off");
  chk_start_pulse: assert property (cycle_start_o |=> !cycle_start_o)
    else $error("start pulse long");
  chk_on_at_start: assert property ($rose(switch_on_o) |-> cycle_start_o)
    else $error("switch on off start");
  chk_code_hold: assert property (switch_on_o && !cycle_start_o |-> $stable(ilim_code_o))
    else $error("code moved");
  chk_period_span: assert property (seen && cycle_start_o |-> gap >= 11'h397 && gap <= 11'h3D0)
    else $error("period out of span");
  chk_window_stop: assert property ($fell(max_duty_window_o) |-> ##1 !switch_on_o)
    else $error("on past window");
  chk_ilim_stop: assert property (ilim_reached_i [*3] |=> !switch_on_o || cycle_start_o)
    else $error("on past limit");
  chk_vhigh_fire: assert property (cycle_start_o && $past(load_state_o) == 2'h3 && !$past(line_uv_active_o) |-> switch_on_o && ilim_code_o[1])
    else $error("very high skipped");
  chk_level_map: assert property (cycle_start_o && switch_on_o && $past(load_state_o) != 2'h3 |-> ilim_code_o == $past(load_state_o) + 2'h1)
    else $error("wrong level");
  chk_uv_block: assert property (line_uv_active_o && $past(line_uv_active_o) && cycle_start_o |-> !switch_on_o)
    else $error("fired in uv");
  cover property (cycle_start_o && !switch_on_o);
  cover property (cycle_start_o && ilim_code_o == 2'h2 && $past(load_state_o) == 2'h3);
  cover property ($fell(switch_on_o) && max_duty_window_o);
endmodule // ocs_monitor
bind ocs_ctrl ocs_monitor mon_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .ilim_reached_i(ilim_reached_i),
  .switch_on_o(switch_on_o), .ilim_code_o(ilim_code_o), .load_state_o(load_state_o),
  .line_uv_active_o(line_uv_active_o), .cycle_start_o(cycle_start_o),
  .max_duty_window_o(max_duty_window_o));
`default_nettype wire

//--- bench/ocs_ctrl_tb_top.sv
// bench for the cycle-skip controller
// assumes the feedback partner and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "ocs_map.vh"
module ocs_ctrl_tb_top;
  logic clk_i = 1'b0, rst_b = 1'b0, demand = 1'b0, res_p = 1'b0, uv = 1'b0;
  logic [9:0] ramp = 10'h0;
  logic en_w, ilim, sw_on, uv_act, cs, win;
  logic [1:0] code, lst, st = 2'h0;
  logic [15:0] hist = 16'h0;
  int fail_count = 0, compares = 0;
  initial forever #4 clk_i = ~clk_i;
  ocs_fb_model fb_u (.clk_i(clk_i), .demand_i(demand), .ramp_i(ramp), .switch_on_i(sw_on),
    .enable_o(en_w), .ilim_reached_o(ilim));
  ocs_ctrl dut_u (.clk_i(clk_i), .rst_b_i(rst_b), .feedback_enable_input_i(en_w),
    .line_resistor_present_i(res_p), .line_uv_i(uv), .ilim_reached_i(ilim), .switch_on_o(sw_on),
    .ilim_code_o(code), .load_state_o(lst), .line_uv_active_o(uv_act), .cycle_start_o(cs),
    .max_duty_window_o(win));
  task chk(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wait_start;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (cs !== 1'b1 && n < 1100);
    if (cs !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, cs, 1'b1);
    end
  endtask
  task run_cycle(input logic en);
    logic [1:0] xc;
    logic xf;
    int n;
    xf = st == 2'h3 || en;
    xc = st == 2'h3 ? (en ? `OCS_ILIM_FULL : `OCS_ILIM_HALF) : (en ? st + 2'h1 : `OCS_ILIM_OFF);
    @(posedge clk_i) demand <= en;
    wait_start;
    chk({1'b0, sw_on}, {1'b0, xf});
    chk(code, xc);
    n = $countones(hist);
    st = n >= `OCS_TH_VHIGH ? 2'h3 : (n >= `OCS_TH_HIGH ? 2'h2 : (n >= `OCS_TH_MED ? 2'h1 : 2'h0));
    chk(lst, st);
    hist = {hist[14:0], en};
    @(posedge clk_i) demand <= !en;
    repeat (20) @(posedge clk_i);
    #1 chk({1'b0, sw_on}, {1'b0, xf});
    chk({1'b0, win}, 2'h1);
  endtask
  // full load, then two lows that still fire at half limit, a high, and a last low skipped once the state steps down to high
  task sc_heavy;
    repeat (16) run_cycle(1'b1);
    repeat (2) run_cycle(1'b0);
    run_cycle(1'b1);
    run_cycle(1'b0);
  endtask
  task sc_light;
    for (int i = 0; i < 20; i++) run_cycle(i % 4 == 0);
  endtask
  task sc_ilim;
    @(posedge clk_i) ramp <= 10'h32;
    run_cycle(1'b1);
    repeat (40) @(posedge clk_i);
    #1 chk({1'b0, sw_on}, 2'h0);
    @(posedge clk_i) ramp <= 10'h0;
  endtask
  task sc_uv;
    @(posedge clk_i) res_p <= 1'b1;
    uv <= 1'b1;
    demand <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1 chk({1'b0, uv_act}, 2'h1);
    wait_start;
    chk({1'b0, sw_on}, 2'h0);
    @(posedge clk_i) res_p <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1 chk({1'b0, uv_act}, 2'h0);
  endtask
  initial begin
    repeat (80000) @(posedge clk_i);
    fail_count++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_b <= 1'b1;
    sc_heavy;
    sc_light;
    sc_ilim;
    sc_uv;
    test_done;
  end
endmodule // ocs_ctrl_tb_top
`default_nettype wire

//--- bench/ocs_fb_model.sv
// feedback and current-sense partner of the controller
// assumes the bench sets demand and ramp length
`timescale 1ns/1ns
`default_nettype none
module ocs_fb_model (
  // clock
  input wire logic clk_i,
  // stimulus from bench
  input wire logic demand_i,
  input wire logic [9:0] ramp_i,
  // to and from the controller
  input wire logic switch_on_i,
  output logic enable_o,
  output logic ilim_reached_o
);
  logic [9:0] ramp_cnt = 10'h0;
  logic hit = 1'b0;
  assign ilim_reached_o = hit;
  // optocoupler: pulls enable low once the output is above target
  assign enable_o = demand_i;
  // zero ramp never reaches the limit, so the duty window ends the pulse
  always @(posedge clk_i) begin
    ramp_cnt <= switch_on_i ? ramp_cnt + 10'h1 : 10'h0;
    hit <= switch_on_i && ramp_i != 10'h0 && ramp_cnt >= ramp_i;
  end
endmodule // ocs_fb_model
`default_nettype wire

//--- inc/ocs_map.vh
// constants for the on/off cycle-skip controller
// assumes a 125 MHz core clock; included by bare name
`ifndef OCS_MAP_VH
`define OCS_MAP_VH

// ----------------------------------------
// oscillator timing
// ----------------------------------------
`define OCS_CLK_KHZ 125000
`define OCS_FOSC_KHZ 132
`define OCS_JIT_PP_KHZ 8
`define OCS_JIT_RATE_KHZ 1
// period counts in clk cycles: 125000/128 .. 125000/136 around 125000/132
`define OCS_PER_NOM (`OCS_CLK_KHZ / `OCS_FOSC_KHZ)
`define OCS_PER_MAX (`OCS_CLK_KHZ / (`OCS_FOSC_KHZ - `OCS_JIT_PP_KHZ / 2))
`define OCS_PER_MIN (`OCS_CLK_KHZ / (`OCS_FOSC_KHZ + `OCS_JIT_PP_KHZ / 2))
// jitter sweep: one triangle sweep per 1 ms, stepped once per oscillator cycle
`define OCS_JIT_STEPS (`OCS_FOSC_KHZ / `OCS_JIT_RATE_KHZ / 2)
// max duty window as a fraction of the period, in 1/64 units
`define OCS_DMAX_64THS 42

// ----------------------------------------
// current-limit codes
// ----------------------------------------
`define OCS_ILIM_OFF 2'h0
`define OCS_ILIM_LOW 2'h1
`define OCS_ILIM_HALF 2'h2
`define OCS_ILIM_FULL 2'h3

// ----------------------------------------
// load classification
// ----------------------------------------
`define OCS_WIN_LEN 16
`define OCS_TH_VHIGH 5'h0F
`define OCS_TH_HIGH 5'h0A
`define OCS_TH_MED 5'h05

`endif

//--- verilog/ocs_ctrl.v
// on/off cycle-skip controller with current-limit state machine
// assumes enable and current-limit comparator levels arrive asynchronously
`timescale 1ns/1ns
`default_nettype none
`include "ocs_map.vh"

module ocs_ctrl (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // feedback enable level, high while pull-out current is under threshold
  input wire feedback_enable_input_i,
  // line sense
  input wire line_resistor_present_i,
  input wire line_uv_i,
  // current sense comparator, high when switch current reaches selected limit
  input wire ilim_reached_i,
  // switch drive
  output reg switch_on_o,
  output reg [1:0] ilim_code_o,
  // status
  output reg [1:0] load_state_o,
  output reg line_uv_active_o,
  output wire cycle_start_o,
  output wire max_duty_window_o
);
  localparam [1:0] LS_LIGHT = 2'h0;
  localparam [1:0] LS_MED = 2'h1;
  localparam [1:0] LS_HIGH = 2'h2;
  localparam [1:0] LS_VHIGH = 2'h3;
  localparam integer WIN_LEN_I = `OCS_WIN_LEN;
  localparam [4:0] WIN_LEN = WIN_LEN_I[4:0];

  reg en_s1;
  reg en_s2;
  reg il_s1;
  reg il_s2;
  reg lr_s1;
  reg lr_s2;
  reg uv_s1;
  reg uv_s2;
  reg [WIN_LEN-1:0] hist;
  reg [4:0] en_count;
  reg [1:0] next_load;
  reg fire;
  reg [1:0] next_code;
  reg start_pulse;
  reg duty_window;
  wire cyc;
  wire win;

  // ----------------------------------------
  // oscillator
  // ----------------------------------------
  ocs_osc u_osc (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .cycle_start_o(cyc),
    .max_duty_window_o(win)
  );
  assign cycle_start_o = start_pulse;
  assign max_duty_window_o = duty_window;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // the enable level already reflects the over-threshold comparator
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      il_s1 <= 1'b0;
      il_s2 <= 1'b0;
      lr_s1 <= 1'b0;
      lr_s2 <= 1'b0;
      uv_s1 <= 1'b0;
      uv_s2 <= 1'b0;
    end else begin
      en_s1 <= feedback_enable_input_i;
      en_s2 <= en_s1;
      il_s1 <= ilim_reached_i;
      il_s2 <= il_s1;
      lr_s1 <= line_resistor_present_i;
      lr_s2 <= lr_s1;
      uv_s1 <= line_uv_i;
      uv_s2 <= uv_s1;
    end
  end

  // ----------------------------------------
  // load classification
  // ----------------------------------------
  // thresholds are tested from the top down so that a full window always
  // lands in the very-high state
  function [1:0] load_class;
    input [4:0] count;
    begin
      if (count >= `OCS_TH_VHIGH) begin
        load_class = LS_VHIGH;
      end else if (count >= `OCS_TH_HIGH) begin
        load_class = LS_HIGH;
      end else if (count >= `OCS_TH_MED) begin
        load_class = LS_MED;
      end else begin
        load_class = LS_LIGHT;
      end
    end
  endfunction

  // ----------------------------------------
  // current-limit level per state and sample
  // ----------------------------------------
  // an off code means the cycle is skipped; only the very-high state turns a
  // low sample into a pulse, at the half level
  function [1:0] limit_code;
    input [1:0] state;
    input sample;
    begin
      case (state)
        LS_VHIGH: begin
          limit_code = sample ? `OCS_ILIM_FULL : `OCS_ILIM_HALF;
        end
        LS_HIGH: begin
          limit_code = sample ? `OCS_ILIM_FULL : `OCS_ILIM_OFF;
        end
        LS_MED: begin
          limit_code = sample ? `OCS_ILIM_HALF : `OCS_ILIM_OFF;
        end
        default: begin
          limit_code = sample ? `OCS_ILIM_LOW : `OCS_ILIM_OFF;
        end
      endcase
    end
  endfunction

  // ----------------------------------------
  // fire decision
  // ----------------------------------------
  always @* begin
    next_load = load_class(en_count);
    next_code = limit_code(load_state_o, en_s2);
    fire = (next_code != `OCS_ILIM_OFF);
    // line under-voltage only blocks switching when a sense resistor exists
    if (line_uv_active_o) begin
      fire = 1'b0;
    end
  end

  // ----------------------------------------
  // sample history and load state
  // ----------------------------------------
  // the window holds the last WIN_LEN samples; count tracks its popcount so
  // no adder tree is needed; a cycle is judged on the state set one cycle before
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hist <= {WIN_LEN{1'b0}};
      en_count <= 5'h00;
      load_state_o <= LS_LIGHT;
    end else if (cyc) begin
      // only sampled here; later enable changes have no effect this cycle
      hist <= {hist[WIN_LEN-2:0], en_s2};
      en_count <= en_count + {4'h0, en_s2} - {4'h0, hist[WIN_LEN-1]};
      load_state_o <= next_load;
    end
  end

  // ----------------------------------------
  // switch drive
  // ----------------------------------------
  // the code is cleared with the switch so a stale level never shows while off
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      switch_on_o <= 1'b0;
      ilim_code_o <= `OCS_ILIM_OFF;
      line_uv_active_o <= 1'b0;
    end else begin
      line_uv_active_o <= lr_s2 & uv_s2;
      if (cyc) begin
        switch_on_o <= fire;
        ilim_code_o <= fire ? next_code : `OCS_ILIM_OFF;
      end else if (switch_on_o && (il_s2 || !win)) begin
        switch_on_o <= 1'b0;
        ilim_code_o <= `OCS_ILIM_OFF;
      end
    end
  end

  // ----------------------------------------
  // timing outputs
  // ----------------------------------------
  // the oscillator pulses are delayed one clock to line up with the decision
  // taken on them, so pulse, switch and code change on the same edge
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_pulse <= 1'b0;
      duty_window <= 1'b0;
    end else begin
      start_pulse <= cyc;
      duty_window <= win;
    end
  end
endmodule // ocs_ctrl

`default_nettype wire

//--- verilog/ocs_osc.v
// jittered cycle oscillator: cycle-start pulse and max duty window
// assumes a single clk_i domain; no external pins
`timescale 1ns/1ns
`default_nettype none
`include "ocs_map.vh"

module ocs_osc (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // timing outputs
  output reg cycle_start_o,
  output reg max_duty_window_o
);
  localparam integer PER_MIN_I = `OCS_PER_MIN;
  localparam integer PER_MAX_I = `OCS_PER_MAX;
  localparam integer PER_NOM_I = `OCS_PER_NOM;
  localparam integer JIT_STEPS_I = `OCS_JIT_STEPS;
  localparam integer DMAX_I = `OCS_DMAX_64THS;
  localparam [10:0] PER_MIN = PER_MIN_I[10:0];
  localparam [10:0] PER_MAX = PER_MAX_I[10:0];
  localparam [10:0] PER_NOM = PER_NOM_I[10:0];
  localparam [6:0] JIT_STEPS = JIT_STEPS_I[6:0];
  localparam [16:0] DMAX_64THS = DMAX_I[16:0];

  reg [10:0] cnt;
  reg [10:0] period;
  reg [6:0] step;
  reg sweep_up;
  wire [16:0] dmax_prod;
  wire [10:0] dmax_len;
  wire wrap;

  // ----------------------------------------
  // period counter, jitter swept triangle-wise
  // ----------------------------------------
  // the period walks linearly between the extremes; a triangle spreads energy
  // evenly, which a sine would not, at no extra area
  // the product needs 16 bits; an 11-bit product would wrap and shrink the window
  assign dmax_prod = {6'h00, period} * DMAX_64THS;
  assign dmax_len = dmax_prod[16:6];
  assign wrap = (cnt >= period - 11'h001);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 11'h000;
      period <= PER_NOM;
      step <= 7'h00;
      sweep_up <= 1'b1;
      cycle_start_o <= 1'b0;
      max_duty_window_o <= 1'b0;
    end else begin
      cycle_start_o <= wrap;
      max_duty_window_o <= wrap | (cnt < dmax_len - 11'h001 && !wrap);
      if (wrap) begin
        cnt <= 11'h000;
        if (step == JIT_STEPS - 7'h01) begin
          step <= 7'h00;
          sweep_up <= ~sweep_up;
        end else begin
          step <= step + 7'h01;
        end
        if (sweep_up && period < PER_MAX) begin
          period <= period + ((PER_MAX - PER_MIN) / {4'h0, JIT_STEPS} + 11'h001);
        end else if (!sweep_up && period > PER_MIN) begin
          period <= period - ((PER_MAX - PER_MIN) / {4'h0, JIT_STEPS} + 11'h001);
        end
      end else begin
        cnt <= cnt + 11'h001;
      end
    end
  end
endmodule // ocs_osc

`default_nettype wire
